// ==== src/csd_map.vh ====
// Constants for the compare-skip and decimal-adjust execution block
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// Opcode fields
`define CSD_OP_HI 4'h6
`define CSD_SUB_EQ 3'h1
`define CSD_SUB_GT 3'h2
`define CSD_SUB_LT 3'h0
`define CSD_DAW_OP 16'h0007
// Decimal adjust
`define CSD_NIB_MAX 4'h9
`define CSD_NIB_ADJ 4'h6
// Addressing
`define CSD_IDX_LIMIT 8'h5F
`define CSD_ACC_SPLIT 8'h60
`define CSD_ACC_HI_BANK 4'hF
`define CSD_ACC_LO_BANK 4'h0
// Wishbone register offsets (byte addresses)
`define CSD_REG_CTRL 4'h0
`define CSD_REG_INSTR 4'h4
`define CSD_REG_WORKING_REGISTER 4'h8
`define CSD_REG_STAT 4'hC
// Control bits
`define CSD_CTRL_EXT 0
`define CSD_CTRL_TWO 1
`define CSD_CTRL_BSR_LO 4
// Status bits
`define CSD_ST_BUSY 0
`define CSD_ST_SKIP 1
`define CSD_ST_C 2
`define CSD_ST_DC 3
`define CSD_ST_CYC_LO 4
`define CSD_ST_ADDR_LO 8
// Instruction word fields
`define CSD_F_ADDR_HI 7
`define CSD_F_ADDR_LO 0
`define CSD_F_ACC 8
`define CSD_F_SUB_HI 11
`define CSD_F_SUB_LO 9
`define CSD_F_OP_HI 15
`define CSD_F_OP_LO 12
`define CSD_BORROW_BIT 8
// No-op cycles after a taken skip
`define CSD_NOP_ONE 2'h1
`define CSD_NOP_TWO 2'h2
`endif

// ==== src/csd_core.v ====
// Compare-skip and decimal-adjust execution block with a Wishbone register port
//
// Summary of operation
// RULE1 - Greater compare subtracts working register from file value; skip when file larger.
// RULE2 - Less compare skips only when file value strictly smaller than working register.
// RULE3 - A taken skip discards the prefetched word and adds one no-op cycle.
// RULE4 - Skipping a two-word instruction adds a second no-op cycle, three total.
// RULE5 - Greater compare encoding is 0110 010a with eight-bit file address.
// RULE6 - Less compare encoding is 0110 000a with eight-bit file address.
// RULE7 - Access bit zero addresses the access bank.
// RULE8 - Access bit one forms address from bank select register and file address.
// RULE9 - Extended set with access bit zero uses indexed literal offset up to 5Fh; the code applies it to the greater compare only.
// RULE10 - Compare operands: eight-bit file address, one access bit, one program word.
// RULE11 - Decimal adjust adds 6 to low nibble if above 9 or digit carry set.
// RULE12 - Decimal adjust adds 6 to high nibble and sets carry if above 9 or carry.
// RULE13 - Equal compare skips when file value equals working register.
// RULE14 - Compares change no flags or working register; read in Q2, no Q4 write.
// RULE15 - Decimal adjust takes one cycle, writing working register back in Q4.
`timescale 1ns/1ps
`include "csd_map.vh"

module csd_core
(
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// Data memory read port
	output reg [11:0] mem_addr_o,
	output reg mem_rd_o,
	input wire [7:0] mem_data_i,
	// Indexed base (frame pointer) for indexed literal offset mode
	input wire [11:0] fsr2_i,
	// Fetch pipeline: flush of prefetched word
	output reg flush_o
);

	// Q phases, one-hot
	localparam Q_IDLE = 5'h01;
	localparam Q_1 = 5'h02;
	localparam Q_2 = 5'h04;
	localparam Q_3 = 5'h08;
	localparam Q_4 = 5'h10;

	reg [4:0] q_r;
	reg [15:0] instr_r;
	reg [7:0] working_register_r;
	reg [7:0] file_val_r;
	reg carry_r;
	reg digit_carry_flag_r;
	reg ext_en_r;
	reg two_word_r;
	reg [3:0] bank_select_register_r;
	reg skip_r;
	reg [1:0] nop_left_r;
	reg [1:0] cycles_r;
	reg [11:0] addr_r;

	// Instruction fields
	wire [7:0] faddr = instr_r[`CSD_F_ADDR_HI:`CSD_F_ADDR_LO]; // see RULE10
	wire acc_bit = instr_r[`CSD_F_ACC]; // see RULE10
	wire [3:0] op_hi = instr_r[`CSD_F_OP_HI:`CSD_F_OP_LO];
	wire [2:0] op_sub = instr_r[`CSD_F_SUB_HI:`CSD_F_SUB_LO];
	wire is_cmp_hi = (op_hi == `CSD_OP_HI);
	wire is_eq = is_cmp_hi && (op_sub == `CSD_SUB_EQ); // see RULE13
	wire is_gt = is_cmp_hi && (op_sub == `CSD_SUB_GT); // see RULE5
	wire is_lt = is_cmp_hi && (op_sub == `CSD_SUB_LT); // see RULE6
	wire is_cmp = is_eq | is_gt | is_lt;
	wire is_daw = (instr_r == `CSD_DAW_OP);

	// Unsigned subtraction f - W; borrow means f < W
	wire [8:0] diff = {1'h0, file_val_r} - {1'h0, working_register_r}; // see RULE1
	wire f_lt_w = diff[`CSD_BORROW_BIT]; // see RULE2
	wire f_eq_w = (diff[`CSD_F_ADDR_HI:`CSD_F_ADDR_LO] == 8'h00);
	// Terms kept apart so a wrong encoding disturbs one compare only
	wire take_eq = is_eq && f_eq_w; // see RULE13
	wire take_gt = is_gt && !f_lt_w && !f_eq_w; // see RULE1
	wire take_lt = is_lt && f_lt_w; // see RULE2
	wire cond = take_eq || take_gt || take_lt;

	// Decimal adjust: each nibble is corrected on its own, the low one never carries up
	wire [3:0] lo_nib;
	wire [3:0] hi_nib;
	wire hi_adj;

	csd_nib_adj
	#(
		.NIB_W(4)
	)
	u_lo_adj
	(
		.nib_i(working_register_r[3:0]),
		.force_i(digit_carry_flag_r),
		.nib_o(lo_nib),
		.adj_o()
	); // see RULE11

	csd_nib_adj
	#(
		.NIB_W(4)
	)
	u_hi_adj
	(
		.nib_i(working_register_r[7:4]),
		.force_i(carry_r),
		.nib_o(hi_nib),
		.adj_o(hi_adj)
	); // see RULE12

	// Data address formation
	reg [11:0] addr_nxt;
	always @*
	begin
		if (acc_bit)
		begin
			addr_nxt = {bank_select_register_r, faddr}; // see RULE8
		end
		else if (ext_en_r && is_gt && (faddr <= `CSD_IDX_LIMIT))
		begin
			// Indexed literal offset: base pointer plus literal
			addr_nxt = fsr2_i + {4'h0, faddr}; // see RULE9
		end
		else if (faddr < `CSD_ACC_SPLIT)
		begin
			addr_nxt = {`CSD_ACC_LO_BANK, faddr}; // see RULE7
		end
		else
		begin
			addr_nxt = {`CSD_ACC_HI_BANK, faddr}; // see RULE7
		end
	end

	// Bus decode; a new request is only taken once ack has dropped
	wire wb_hit = cyc_i && stb_i && !ack_o;
	wire busy = (q_r != Q_IDLE);
	wire wr_lane0 = wb_hit && we_i && sel_i[0];
	wire wr_ctrl = wr_lane0 && (adr_i == `CSD_REG_CTRL);
	// Working register and flags are locked while an instruction runs
	wire wr_working_register = wr_lane0 && (adr_i == `CSD_REG_WORKING_REGISTER) && !busy;
	wire wr_stat = wr_lane0 && (adr_i == `CSD_REG_STAT) && !busy;
	wire rd_take = wb_hit && !we_i;
	wire start = wb_hit && we_i && (adr_i == `CSD_REG_INSTR) && !busy && ce_i;

	// Sequencer
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q_r <= Q_IDLE;
			instr_r <= 16'h0000;
			file_val_r <= 8'h00;
			skip_r <= 1'b0;
			nop_left_r <= 2'h0;
			cycles_r <= 2'h0;
			addr_r <= 12'h000;
			mem_addr_o <= 12'h000;
			mem_rd_o <= 1'b0;
			flush_o <= 1'b0;
			working_register_r <= 8'h00;
			carry_r <= 1'b0;
			digit_carry_flag_r <= 1'b0;
		end
		else if (ce_i)
		begin
			mem_rd_o <= 1'b0;
			flush_o <= 1'b0;
			if (wr_working_register)
			begin
				working_register_r <= dat_i[7:0];
			end
			if (wr_stat)
			begin
				carry_r <= dat_i[`CSD_ST_C];
				digit_carry_flag_r <= dat_i[`CSD_ST_DC];
			end
			case (q_r)
			Q_IDLE:
			begin
				if (start)
				begin
					instr_r <= dat_i[15:0];
					q_r <= Q_1;
					skip_r <= 1'b0;
					cycles_r <= 2'h1;
				end
			end
			Q_1:
			begin
				q_r <= Q_2;
				if (nop_left_r == 2'h0)
				begin
					addr_r <= addr_nxt;
				end
			end
			Q_2:
			begin
				q_r <= Q_3;
				if ((nop_left_r == 2'h0) && is_cmp)
				begin
					// Read only; compares never write back
					mem_addr_o <= addr_r; // see RULE14
					mem_rd_o <= 1'b1;
				end
			end
			Q_3:
			begin
				q_r <= Q_4;
				if ((nop_left_r == 2'h0) && is_cmp)
				begin
					file_val_r <= mem_data_i;
				end
			end
			Q_4:
			begin
				if (nop_left_r != 2'h0)
				begin
					nop_left_r <= nop_left_r - 2'h1;
					cycles_r <= cycles_r + 2'h1;
					q_r <= (nop_left_r == 2'h1) ? Q_IDLE : Q_1;
				end
				else if (is_cmp && cond)
				begin
					skip_r <= 1'b1;
					flush_o <= 1'b1; // see RULE3
					nop_left_r <= two_word_r ? `CSD_NOP_TWO : `CSD_NOP_ONE; // see RULE4
					q_r <= Q_1;
				end
				else
				begin
					if (is_daw)
					begin
						working_register_r <= {hi_nib, lo_nib}; // see RULE15
						if (hi_adj)
						begin
							carry_r <= 1'b1; // see RULE12
						end
					end
					q_r <= Q_IDLE;
				end
			end
			default:
			begin
				q_r <= Q_IDLE;
			end
			endcase
		end
	end

	// Register read mux; status cycle count sits in bits 5:4, data address in 19:8
	wire [31:0] ctrl_word = {24'h000000, bank_select_register_r, 2'h0, two_word_r, ext_en_r};
	wire [31:0] instr_word = {16'h0000, instr_r};
	wire [31:0] working_register_word = {24'h000000, working_register_r};
	wire [31:0] stat_word = {12'h000, addr_r, 2'h0, cycles_r, digit_carry_flag_r, carry_r,
		skip_r, busy};
	reg [31:0] rd_nxt;
	always @*
	begin
		rd_nxt = 32'h00000000;
		if (rd_take)
		begin
			case (adr_i)
			`CSD_REG_CTRL:
			begin
				rd_nxt = ctrl_word;
			end
			`CSD_REG_INSTR:
			begin
				rd_nxt = instr_word;
			end
			`CSD_REG_WORKING_REGISTER:
			begin
				rd_nxt = working_register_word;
			end
			`CSD_REG_STAT:
			begin
				rd_nxt = stat_word;
			end
			default:
			begin
				rd_nxt = 32'h00000000;
			end
			endcase
		end
	end

	// Wishbone slave: control register and one-cycle ack
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			ext_en_r <= 1'b0;
			two_word_r <= 1'b0;
			bank_select_register_r <= 4'h0;
		end
		else if (ce_i)
		begin
			ack_o <= wb_hit;
			if (wr_ctrl)
			begin
				ext_en_r <= dat_i[`CSD_CTRL_EXT];
				two_word_r <= dat_i[`CSD_CTRL_TWO];
				bank_select_register_r <= dat_i[`CSD_CTRL_BSR_LO +: 4];
			end
			dat_o <= rd_nxt;
		end
	end

endmodule

// One decimal-correction nibble; the sum wraps inside the nibble, the caller owns any carry
module csd_nib_adj
#(
	parameter NIB_W = 4
)
(
	// Nibble and forcing flag
	input wire [NIB_W-1:0] nib_i,
	input wire force_i,
	// Corrected nibble and adjust indication
	output wire [NIB_W-1:0] nib_o,
	output wire adj_o
);

	wire [NIB_W-1:0] sum = nib_i + `CSD_NIB_ADJ;

	assign adj_o = (nib_i > `CSD_NIB_MAX) || force_i;
	assign nib_o = adj_o ? sum : nib_i;

endmodule

// ==== tb/csd_core_properties.sv ====
// Port checker for the compare-skip block
`timescale 1ns/1ps
module csd_core_properties (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Observed ports
	input wire ce_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire mem_rd_o,
	input wire flush_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_rst; $fell(rst_i) |-> !ack_o && !mem_rd_o && !flush_o; endproperty
	a_rst: assert property (p_rst) else $error("output set after reset");
	property p_ack; cyc_i && stb_i && ce_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_src; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack unasked");
	property p_rd_one; mem_rd_o |=> !mem_rd_o; endproperty
	a_rd_one: assert property (p_rd_one) else $error("read too long");
	property p_rd_src; mem_rd_o |-> $past(ack_o, 2); endproperty
	a_rd_src: assert property (p_rd_src) else $error("read misplaced");
	property p_fl_src; flush_o |-> $past(mem_rd_o, 2); endproperty
	a_fl_src: assert property (p_fl_src) else $error("flush misplaced");
	property p_fl_gap; flush_o |=> (!flush_o && !mem_rd_o) [*4]; endproperty
	a_fl_gap: assert property (p_fl_gap) else $error("no-op cycles broken");
endmodule
bind csd_core csd_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .mem_rd_o(mem_rd_o), .flush_o(flush_o));

// ==== tb/csd_core_tb.sv ====
// Bench for the compare-skip block
`timescale 1ns/1ps
module csd_core_tb;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, mem_rd_o, flush_o;
	logic [3:0] adr_i;
	logic [7:0] mem_data_i;
	logic [11:0] mem_addr;
	logic [31:0] dat_i, dat_o, q;
	logic [75:0] r;
	logic [75:0] rows [0:10];
	integer bad_count = 0, n_tests = 0, i;
	csd_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.mem_addr_o(mem_addr), .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i),
		.fsr2_i(12'h120), .flush_o(flush_o));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hang;
		bad_count++;
		give_verdict;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
		integer k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack_o !== 1'b1 && k < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1)
			hang;
	endtask
	// Busy clears only after the skip no-op cycles
	task automatic settle;
		integer k;
		k = 0;
		do
		begin
			wb(1'b0, 4'hC, 16'h0000);
			k++;
		end
		while (q[0] !== 1'b0 && k < 40);
		if (q[0] !== 1'b0)
			hang;
	endtask
	initial
	begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 4'h0;
		dat_i = 32'h0;
		mem_data_i = 8'h00;
		// instr, ctrl, w, mem, flags, w after, status, address
		rows[0] = 76'h6410_00_05_06_0C_05_2E_010;
		rows[1] = 76'h6080_02_05_04_0C_05_3E_F80;
		rows[2] = 76'h6360_A0_07_07_0C_07_2E_A60;
		rows[3] = 76'h645F_01_00_FF_0C_00_2E_17F;
		rows[4] = 76'h6460_01_FF_FF_0C_FF_1C_F60;
		rows[5] = 76'h61FF_50_80_01_0C_80_2E_5FF;
		rows[6] = 76'h6122_30_44_44_00_44_10_322;
		rows[7] = 76'h0007_00_A2_00_00_02_14_000;
		rows[8] = 76'h0007_00_99_00_0C_FF_1C_000;
		rows[9] = 76'h6310_00_05_06_00_05_10_010;
		rows[10] = 76'h0007_00_1B_00_00_11_10_000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({29'h0, ack_o, flush_o, mem_rd_o}, 32'h0);
		for (i = 0; i < 11; i++)
		begin
			r = rows[i];
			mem_data_i <= r[43:36];
			wb(1'b1, 4'h0, {8'h00, r[59:52]});
			wb(1'b1, 4'h8, {8'h00, r[51:44]});
			wb(1'b1, 4'hC, {8'h00, r[35:28]});
			wb(1'b1, 4'h4, r[75:60]);
			settle;
			chk({27'h0, q[5:1]}, {27'h0, r[17:13]});
			if (r[75:72] == 4'h6)
			begin
				chk({20'h0, q[19:8]}, {20'h0, r[11:0]});
				chk({20'h0, mem_addr}, {20'h0, r[11:0]});
			end
			wb(1'b0, 4'h8, 16'h0000);
			chk({24'h0, q[7:0]}, {24'h0, r[27:20]});
			$display("row %0d done", i);
		end
		mem_data_i <= 8'h06;
		wb(1'b1, 4'h0, 16'h0000);
		wb(1'b1, 4'h8, 16'h0005);
		wb(1'b1, 4'h4, 16'h6410);
		wb(1'b1, 4'h8, 16'h00EE);
		settle;
		wb(1'b0, 4'h8, 16'h0000);
		chk({24'h0, q[7:0]}, 32'h5);
		wb(1'b0, 4'h1, 16'h0000);
		chk(q, 32'h0);
		$display("busy and unmapped tests done");
		wb(1'b1, 4'h4, 16'h6410);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({29'h0, ack_o, flush_o, mem_rd_o}, 32'h0);
		wb(1'b0, 4'hC, 16'h0000);
		chk(q, 32'h0);
		wb(1'b0, 4'h8, 16'h0000);
		chk(q, 32'h0);
		$display("mid-run reset test done");
		give_verdict;
	end
endmodule
